// ---- common/aux_watchdog_regs.svh ----
/*
 * Register map, field positions, reset values and timing counts of the watchdog.
 * Assumes a 250 MHz register clock and a 32-bit APB with word-aligned registers.
 */
`ifndef AUX_WATCHDOG_REGS_SVH
`define AUX_WATCHDOG_REGS_SVH

// Register indices
`define WDT_UNITS_IDX      8'hf1
`define WDT_COUNT_IDX      8'hf2
`define WDT_CONF_IDX       8'hf3
`define WDT_CSR_IDX        8'hf4

// Byte addresses, four times the index
`define WDT_UNITS_ADDR     {2'b00, `WDT_UNITS_IDX, 2'b00}
`define WDT_COUNT_ADDR     {2'b00, `WDT_COUNT_IDX, 2'b00}
`define WDT_CONF_ADDR      {2'b00, `WDT_CONF_IDX, 2'b00}
`define WDT_CSR_ADDR       {2'b00, `WDT_CSR_IDX, 2'b00}

// Field positions
`define WDT_UNITS_SEC_BIT  7
`define WDT_CSR_STAT_BIT   0
`define WDT_CSR_FORCE_BIT  2
`define WDT_CSR_EXTEN_BIT  3

// Reset values
`define WDT_REG_RESET      8'h00

// Timing
`define WDT_CLK_NS         4
`define WDT_SECOND_NS      1000000000
`define WDT_SEC_CYCLES     (`WDT_SECOND_NS / `WDT_CLK_NS)
`define WDT_MIN_SECONDS    60

`endif

// ---- common/aux_watchdog_pkg.sv ----
/*
 * Types shared by the watchdog design: APB carrier structs and the timer states.
 * Assumes a 12-bit byte address and 32-bit data on the register bus.
 */
package aux_watchdog_pkg;

	// APB request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// APB answer from the slave
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	// Timer states
	typedef enum logic [1:0] {
		WDT_IDLE    = 2'b00,
		WDT_RUN     = 2'b01,
		WDT_EXPIRED = 2'b10
	} wdt_state_t;

endpackage

// ---- core/wdt_edge_detect.sv ----
/*
 * Synchroniser and self-clearing rising-edge detector for the keyboard force pin.
 * Assumes the pin is asynchronous to clk_i; the pulse lasts one clock.
 */
`timescale 1ns/1ps
module wdt_edge_detect (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Pin and gating
	input  wire logic pin_i,
	input  wire logic enable_i,
	// Event
	output logic      pulse_o
);

	logic [2:0] sh_r;
	logic [2:0] sh_nxt;
	logic       pulse_r;
	logic       pulse_nxt;

	////////////////////////////////////////////////////////////////
	// Two sync stages, then a history stage; only sh_r[1] reads sh_r[0]
	always_comb begin
		sh_nxt    = {sh_r[1], sh_r[0], pin_i};
		pulse_nxt = enable_i & sh_r[1] & ~sh_r[2];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh_r    <= 3'h0;
			pulse_r <= 1'b0;
		end else begin
			sh_r    <= sh_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign pulse_o = pulse_r;

	// One pulse per edge even if the pin stays high
	a_edge_single: assert property (@(posedge clk_i) disable iff (rst_i) pulse_o |=> !pulse_o)
		else $error("edge pulse lasted more than one cycle");

endmodule

// ---- core/aux_watchdog_timer.sv ----
/*
 * Watchdog timer with APB registers: unit select, timeout count, configuration and control/status.
 * Assumes a 250 MHz clock, a synchronous active-high reset and an asynchronous keyboard force pin.
 */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "aux_watchdog_regs.svh"

// Functional notes
// - Unit bit 0 means minutes, 1 seconds
// - Zero count keeps the watchdog disabled
// - Nonzero count is 1 to 255 units
// - Status bit reads 1 after timeout, writable
// - Force bit times out at once, self-clears
// - Enabled rising edge of pin forces timeout
// - Disabled pin activity is ignored
// - Pin edge-detected, ORed with software force
// - Units, count, config reset to zero
// - Units register reserved bits read zero
module aux_watchdog_timer #(
	parameter int unsigned SEC_CYCLES  = `WDT_SEC_CYCLES,
	parameter int unsigned MIN_SECONDS = `WDT_MIN_SECONDS
) (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// APB slave
	input  aux_watchdog_pkg::apb_req_t     apb_req_i,
	output aux_watchdog_pkg::apb_rsp_t     apb_rsp_o,
	// Keyboard controller force pin
	input  wire logic                      kbc_force_output_i,
	// Watchdog outputs
	output logic                           wdt_timeout_o,
	output logic                           wdt_status_o,
	output logic [7:0]                     wdt_config_o
);
	import aux_watchdog_pkg::*;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////
	// Register state
	logic       units_sec_r;
	logic       units_sec_nxt;
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	logic       ext_en_r;
	logic       ext_en_nxt;
	logic       status_r;
	logic       status_nxt;

	// Bus state
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// Timer state
	wdt_state_t  state_r;
	wdt_state_t  state_nxt;
	logic [7:0]  left_r;
	logic [7:0]  left_nxt;
	logic [31:0] presc_r;
	logic [31:0] presc_nxt;
	logic [7:0]  secs_r;
	logic [7:0]  secs_nxt;
	logic        tout_r;
	logic        tout_nxt;

	// Decoded strobes
	logic        access;
	logic        wr_en;
	logic        hit;
	logic        sec_tick;
	logic        unit_tick;
	logic        expire;
	logic        sw_force;
	logic        ext_pulse;
	logic        event_any;
	logic        load_cnt;
	logic [31:0] rd_val;

	////////////////////////////////////////////////////////////////
	// Address decode, used for read, write and error
	function automatic logic [1:0] reg_sel(input logic [11:0] a, output logic ok);
		ok = 1'b1;
		case (a)
			`WDT_UNITS_ADDR: reg_sel = 2'd0;
			`WDT_COUNT_ADDR: reg_sel = 2'd1;
			`WDT_CONF_ADDR:  reg_sel = 2'd2;
			`WDT_CSR_ADDR:   reg_sel = 2'd3;
			default: begin
				reg_sel = 2'd0;
				ok      = 1'b0;
			end
		endcase
	endfunction

	logic [1:0] sel;

	// Bus strobes: one wait state, write lands with pready
	always_comb begin
		sel    = reg_sel(apb_req_i.paddr, hit);
		access = apb_req_i.psel & apb_req_i.penable;
		wr_en  = access & ack_r & apb_req_i.pwrite & hit;
	end

	// Read mux
	always_comb begin
		rd_val = 32'h0000_0000;
		case (sel)
			2'd0: rd_val[`WDT_UNITS_SEC_BIT] = units_sec_r;
			2'd1: rd_val[7:0] = count_r;
			2'd2: rd_val[7:0] = cfg_r;
			2'd3: begin
				rd_val[`WDT_CSR_STAT_BIT]  = status_r;
				rd_val[`WDT_CSR_EXTEN_BIT] = ext_en_r;
			end
			default: rd_val = 32'h0000_0000;
		endcase
		if (!hit) begin
			rd_val = 32'h0000_0000;
		end
	end

	// Bus next state
	always_comb begin
		ack_nxt   = access & ~ack_r;
		rdata_nxt = rdata_r;
		if (access && !ack_r) begin
			rdata_nxt = (apb_req_i.pwrite) ? 32'h0000_0000 : rd_val;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r   <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Answer group
	always_comb begin
		apb_rsp_o.pready  = ack_r;
		apb_rsp_o.pslverr = ack_r & ~hit;
		apb_rsp_o.prdata  = rdata_r;
	end

	////////////////////////////////////////////////////////////////
	// Software-visible registers
	always_comb begin
		units_sec_nxt = units_sec_r;
		count_nxt     = count_r;
		cfg_nxt       = cfg_r;
		ext_en_nxt    = ext_en_r;
		sw_force      = 1'b0;
		load_cnt      = 1'b0;
		if (wr_en) begin
			case (sel)
				2'd0: units_sec_nxt = apb_req_i.pwdata[`WDT_UNITS_SEC_BIT];
				2'd1: begin
					count_nxt = apb_req_i.pwdata[7:0];
					load_cnt  = 1'b1;
				end
				2'd2: cfg_nxt = apb_req_i.pwdata[7:0];
				2'd3: begin
					// Upper bits are not stored
					ext_en_nxt = apb_req_i.pwdata[`WDT_CSR_EXTEN_BIT];
					sw_force   = apb_req_i.pwdata[`WDT_CSR_FORCE_BIT];
				end
				default: cfg_nxt = cfg_r;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			units_sec_r <= 1'b0;
			count_r     <= `WDT_REG_RESET;
			cfg_r       <= `WDT_REG_RESET;
			ext_en_r    <= 1'b0;
		end else begin
			units_sec_r <= units_sec_nxt;
			count_r     <= count_nxt;
			cfg_r       <= cfg_nxt;
			ext_en_r    <= ext_en_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// External force edge detector
	wdt_edge_detect u_edge (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (kbc_force_output_i),
		.enable_i (ext_en_r),
		.pulse_o  (ext_pulse)
	);

	////////////////////////////////////////////////////////////////
	// Unit tick generator and countdown
	always_comb begin
		sec_tick  = (state_r == WDT_RUN) && (presc_r == SEC_CYCLES - 32'd1);
		unit_tick = sec_tick && (units_sec_r || (secs_r == 8'(MIN_SECONDS - 1)));
		expire    = unit_tick && (left_r == 8'h01);
		event_any = sw_force | ext_pulse | expire;
	end

	always_comb begin
		state_nxt = state_r;
		left_nxt  = left_r;
		presc_nxt = presc_r;
		secs_nxt  = secs_r;
		tout_nxt  = event_any;
		case (state_r)
			WDT_IDLE: begin
				presc_nxt = 32'h0;
				secs_nxt  = 8'h00;
			end
			WDT_RUN: begin
				presc_nxt = sec_tick ? 32'h0 : presc_r + 32'h1;
				if (sec_tick) begin
					secs_nxt = (unit_tick) ? 8'h00 : secs_r + 8'h01;
				end
				if (unit_tick) begin
					left_nxt = left_r - 8'h01;
				end
			end
			WDT_EXPIRED: begin
				presc_nxt = 32'h0;
			end
			default: state_nxt = WDT_IDLE;
		endcase
		if (event_any) begin
			state_nxt = WDT_EXPIRED;
		end
		// A fresh count write restarts or disables the timer
		if (load_cnt) begin
			left_nxt  = apb_req_i.pwdata[7:0];
			presc_nxt = 32'h0;
			secs_nxt  = 8'h00;
			state_nxt = (apb_req_i.pwdata[7:0] == 8'h00) ? WDT_IDLE : WDT_RUN;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= WDT_IDLE;
			left_r  <= 8'h00;
			presc_r <= 32'h0;
			secs_r  <= 8'h00;
			tout_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			left_r  <= left_nxt;
			presc_r <= presc_nxt;
			secs_r  <= secs_nxt;
			tout_r  <= tout_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status bit: a timeout event wins over a software write
	always_comb begin
		status_nxt = status_r;
		if (wr_en && sel == 2'd3) begin
			status_nxt = apb_req_i.pwdata[`WDT_CSR_STAT_BIT];
		end
		if (event_any) begin
			status_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
		end
	end

	// Outputs
	assign wdt_timeout_o = tout_r;
	assign wdt_status_o  = status_r;
	assign wdt_config_o  = cfg_r;

	////////////////////////////////////////////////////////////////
	// Checks
	sequence seq_ctrl_rd;
		access && !ack_r && !apb_req_i.pwrite && sel == 2'd3 && hit;
	endsequence

	sequence seq_status_up;
		status_r && wdt_timeout_o;
	endsequence

	a_force_sets: assert property (sw_force |=> seq_status_up)
		else $error("software force did not time out");

	a_force_reads0: assert property (seq_ctrl_rd |=> apb_rsp_o.prdata[`WDT_CSR_FORCE_BIT] == 1'b0)
		else $error("force bit read back as one");

	a_ext_event: assert property (ext_pulse && !load_cnt |=> seq_status_up ##0 state_r == WDT_EXPIRED)
		else $error("pin edge did not time out");

	a_ext_ignored: assert property (!ext_en_r |=> !ext_pulse)
		else $error("pin event while disabled");

	a_zero_disables: assert property (count_r == 8'h00 && !load_cnt |-> !expire && state_r != WDT_RUN)
		else $error("timer runs with zero count");

	a_run_nonzero: assert property (state_r == WDT_RUN |-> left_r != 8'h00)
		else $error("running with nothing left");

	a_load_count: assert property (load_cnt && apb_req_i.pwdata[7:0] != 8'h00
		|=> state_r == WDT_RUN && left_r == $past(apb_req_i.pwdata[7:0]) && presc_r == 32'h0)
		else $error("count write did not load timer");

	a_expire_sets: assert property (expire && !load_cnt |=> status_r && state_r == WDT_EXPIRED && left_r == 8'h00)
		else $error("countdown end did not set status");
	a_minute_rate: assert property (sec_tick && !units_sec_r && !load_cnt
		&& secs_r != 8'(MIN_SECONDS - 1) |=> $stable(left_r))
		else $error("minute unit ticked early");

	a_units_rsvd: assert property (access && !ack_r && !apb_req_i.pwrite && sel == 2'd0 && hit
		|=> apb_rsp_o.prdata[6:0] == 7'h00)
		else $error("reserved unit bits read nonzero");

	a_reset_zero: assert property (disable iff (1'b0) rst_i |=> units_sec_r == 1'b0 && count_r == 8'h00
		&& cfg_r == 8'h00)
		else $error("registers not cleared by reset");

endmodule

// ---- verif/aux_watchdog_timer_tb_top.sv ----
/*
 * Self-checking bench for the watchdog timer: APB register access, countdown, forced and pin timeouts.
 * Assumes the design's one-wait-state APB slave and short unit counts set through its parameters.
 */
`timescale 1ns/1ps
`include "aux_watchdog_regs.svh"
module aux_watchdog_timer_tb_top;
	import aux_watchdog_pkg::*;

	localparam int unsigned SEC = 10;
	localparam int unsigned MINS = 3;

	logic       clk_i;
	logic       rst_i;
	apb_req_t   req;
	apb_rsp_t   rsp;
	apb_rsp_t   rsp_s;
	logic       pin;
	logic       tmo;
	logic       stat;
	logic [7:0] cfg;
	int         n_fail;
	int         n_tests;
	int         n_pulse;

	aux_watchdog_timer #(.SEC_CYCLES(SEC), .MIN_SECONDS(MINS)) dut_u (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.apb_req_i          (req),
		.apb_rsp_o          (rsp),
		.kbc_force_output_i (pin),
		.wdt_timeout_o      (tmo),
		.wdt_status_o       (stat),
		.wdt_config_o       (cfg)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock, settled copy of the answer, pulse counter
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	always @(negedge clk_i) begin
		rsp_s <= rsp;
		if (tmo === 1'b1) n_pulse++;
	end

	////////////////////////////////////////////////////////////////////////
	// Compare tasks and closing
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// APB master: setup, access until pready, release at that edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge clk_i);
		req.penable <= 1'b1;
		// Only the bench watchdog ends this wait
		do begin
			@(posedge clk_i);
		end while (rsp_s.pready !== 1'b1);
		rd  = rsp_s.prdata;
		err = rsp_s.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
		// Idle edge so back-to-back calls never drive psel twice at one time
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, {24'h000000, d}, rd, e);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 32'h00000000, rd, e);
		chk_byte(rd[7:0], exp);
	endtask

	// Cycles from the write edge until status is seen high
	task automatic wait_status(input int lim, output int n);
		n = 0;
		while (stat !== 1'b1 && n < lim) begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		logic [31:0] rd;
		logic        e;
		rd_chk(`WDT_UNITS_ADDR, 8'h00);
		rd_chk(`WDT_COUNT_ADDR, 8'h00);
		rd_chk(`WDT_CONF_ADDR, 8'h00);
		rd_chk(`WDT_CSR_ADDR, 8'h00);
		wr(`WDT_UNITS_ADDR, 8'hff);
		rd_chk(`WDT_UNITS_ADDR, 8'h80);
		wr(`WDT_CONF_ADDR, 8'ha5);
		rd_chk(`WDT_CONF_ADDR, 8'ha5);
		chk_byte(cfg, 8'ha5);
		apb(1'b0, 12'h000, 32'h00000000, rd, e);
		chk_bit(e, 1'b1);
		$display("test reset done");
	endtask

	task automatic t_force();
		n_pulse = 0;
		wr(`WDT_CSR_ADDR, 8'h04);
		@(negedge clk_i);
		chk_bit(n_pulse == 1, 1'b1);
		chk_bit(stat, 1'b1);
		chk_bit(tmo, 1'b0);
		@(posedge clk_i);
		rd_chk(`WDT_CSR_ADDR, 8'h01);
		wr(`WDT_CSR_ADDR, 8'h00);
		rd_chk(`WDT_CSR_ADDR, 8'h00);
		wr(`WDT_CSR_ADDR, 8'h01);
		rd_chk(`WDT_CSR_ADDR, 8'h01);
		wr(`WDT_CSR_ADDR, 8'h00);
		$display("test force done");
	endtask

	task automatic t_count(input logic [7:0] u, input logic [7:0] c, input int exp);
		int n;
		n_pulse = 0;
		wr(`WDT_UNITS_ADDR, u);
		wr(`WDT_COUNT_ADDR, c);
		wait_status(exp + 20, n);
		chk_bit(n >= exp - 1 && n <= exp + 1, 1'b1);
		chk_bit(n_pulse == 1, 1'b1);
		wr(`WDT_CSR_ADDR, 8'h00);
		$display("test count %h units %h done, %0d cycles", c, u, n);
	endtask

	// A running timer is stopped by a zero count, well before it would expire
	task automatic t_zero();
		int n;
		wr(`WDT_UNITS_ADDR, 8'h80);
		wr(`WDT_COUNT_ADDR, 8'h02);
		wr(`WDT_COUNT_ADDR, 8'h00);
		wait_status(300, n);
		chk_bit(stat, 1'b0);
		$display("test zero done");
	endtask

	task automatic t_pin();
		n_pulse = 0;
		pin <= 1'b1;
		repeat (10) @(posedge clk_i);
		pin <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk_bit(n_pulse == 0, 1'b1);
		chk_bit(stat, 1'b0);
		wr(`WDT_CSR_ADDR, 8'h08);
		pin <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk_bit(n_pulse == 1, 1'b1);
		chk_bit(stat, 1'b1);
		repeat (30) @(posedge clk_i);
		chk_bit(n_pulse == 1, 1'b1);
		wr(`WDT_CSR_ADDR, 8'h0c);
		repeat (2) @(posedge clk_i);
		chk_bit(n_pulse == 2, 1'b1);
		pin <= 1'b0;
		wr(`WDT_CSR_ADDR, 8'h00);
		$display("test pin done");
	endtask

	// Reset after a forced timeout clears written registers and status
	task automatic t_rst2();
		wr(`WDT_UNITS_ADDR, 8'h80);
		wr(`WDT_CONF_ADDR, 8'h3c);
		wr(`WDT_COUNT_ADDR, 8'h05);
		wr(`WDT_CSR_ADDR, 8'h05);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_byte(cfg, 8'h00);
		chk_bit(stat, 1'b0);
		rd_chk(`WDT_UNITS_ADDR, 8'h00);
		rd_chk(`WDT_COUNT_ADDR, 8'h00);
		rd_chk(`WDT_CONF_ADDR, 8'h00);
		$display("test mid-run reset done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		rst_i   = 1'b1;
		req     = '0;
		pin     = 1'b0;
		n_fail  = 0;
		n_tests = 0;
		n_pulse = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_force();
		t_count(8'h80, 8'h02, 2 * SEC);
		t_count(8'h80, 8'hff, 255 * SEC);
		t_count(8'h00, 8'h01, MINS * SEC);
		t_zero();
		t_pin();
		t_rst2();
		tally_and_finish();
	end

	initial begin
		#40000;
		n_fail++;
		tally_and_finish();
	end
endmodule
